// ==== rtl/two_wire_pkg.sv ====
/*
 * Constants for the two-wire master transmitter: register map, control
 * field layout, status codes, states and bus timing.
 * Assumes a 20 MHz system clock and an open-drain two-wire bus.
 */
package two_wire_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_ADDR = 2'h0;
	localparam logic [1:0] STAT_ADDR = 2'h1;
	localparam logic [1:0] DATA_ADDR = 2'h2;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int FLAG_BIT  = 7;
	localparam int ACKEN_BIT = 6;
	localparam int STA_BIT   = 5;
	localparam int STO_BIT   = 4;
	localparam int WCOL_BIT  = 3;
	localparam int EN_BIT    = 2;
	localparam int IE_BIT    = 0;

	// ----------------------------------------------------------------
	// Status codes, prescaler bits zero
	// ----------------------------------------------------------------
	localparam logic [7:0] ST_START   = 8'h08;
	localparam logic [7:0] ST_RSTART  = 8'h10;
	localparam logic [7:0] ST_AW_ACK  = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_D_ACK   = 8'h28;
	localparam logic [7:0] ST_D_NACK  = 8'h30;
	localparam logic [7:0] ST_ARB     = 8'h38;
	localparam logic [7:0] ST_AR_ACK  = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_IDLE    = 8'hF8;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] LAST_BIT   = 4'h8;
	localparam logic [3:0] BIT_ZERO   = 4'h0;
	localparam logic [3:0] BIT_ONE    = 4'h1;

	// ----------------------------------------------------------------
	// Bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCL_PERIOD_NS = 400;
	localparam logic [7:0] HALF_CYC = 8'((SCL_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CNT_ONE  = 8'h01;

	// ----------------------------------------------------------------
	// Bus sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		P_IDLE   = 4'h0,
		P_WAIT   = 4'h1,
		P_START  = 4'h2,
		P_SCLLOW = 4'h3,
		P_HOLD   = 4'h4,
		P_BLOW   = 4'h5,
		P_BHIGH  = 4'h6,
		P_RS     = 4'h7,
		P_RSH    = 4'h8,
		P_STOP1  = 4'h9,
		P_STOP2  = 4'hA,
		P_STOP3  = 4'hB,
		P_LOST   = 4'hC
	} phase_t;

endpackage

// ==== rtl/two_wire_master.sv ====
/*
 * Two-wire master transmitter with control, status and data registers
 * on a plain strobe port. Sends START, repeated START, STOP, address
 * and data bytes, and detects lost arbitration.
 * Assumes open-drain bus lines resolved outside and pulled up.
 */
// The register offsets and the plain strobed port were left to the implementer.
// Functional notes
// - Start request with flag, enable waits free bus
// - After START, set flag, status 08
// - Address direction selects transmit or receive mode
// - Address sent: status 18, 20 or 38
// - Status codes read with prescaler bits masked
// - Data write while flag low sets collision
// - Data states send loaded byte on clear
// - Data sent: status 28 or 30
// - Start request in sent states: repeated START
// - Stop request sends STOP, clears stop bit
// - Both requests: STOP then START, bit cleared
// - After repeated START report status 10
// - Read address from 10 enters receive mode
// - Arbitration lost: 38, then release bus
// - In 38 start request waits, starts again
// - 18 and 20 accept same four responses
// - Transfer suspended while flag stays set
`timescale 1ns/10ps
module two_wire_master
	import two_wire_pkg::*;
#(
	parameter logic [7:0] HALF_CYCLES = HALF_CYC
) (
	input  wire logic       clk_i,    // System clock
	input  wire logic       reset_i,  // Synchronous reset
	input  wire logic [1:0] addr_i,   // Register address
	input  wire logic [7:0] wdata_i,  // Write data
	input  wire logic       write_i,  // Write strobe
	input  wire logic       read_i,   // Read strobe
	output logic      [7:0] rdata_o,  // Read data
	input  wire logic       scl_i,    // Clock line level
	output logic            scl_o,    // Clock line drive value
	output logic            scl_oe_o, // Clock line pulled low
	input  wire logic       sda_i,    // Data line level
	output logic            sda_o,    // Data line drive value
	output logic            sda_oe_o, // Data line pulled low
	output logic            irq_o,    // Interrupt request
	output logic            rx_mode_o // Receive mode entered
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	phase_t     phase_ff;
	logic [7:0] cnt_ff;
	logic [7:0] tx_ff;
	logic [3:0] bitc_ff;
	logic [7:0] code_ff;
	logic       flag_ff;
	logic       is_addr_ff;
	logic       dir_ff;
	logic       rs_ff;
	logic       pend_ff;
	logic       rx_ff;
	logic       sto_clr_ff;
	logic       acken_ff;
	logic       sta_ff;
	logic       sto_ff;
	logic       wcol_ff;
	logic       en_ff;
	logic       ie_ff;
	logic [1:0] presc_ff;
	logic [7:0] data_ff;
	logic [7:0] rdata_ff;
	logic       irq_ff;
	logic       scl_oe_ff;
	logic       sda_oe_ff;
	logic       scl_m_ff;
	logic       scl_s_ff;
	logic       sda_m_ff;
	logic       sda_s_ff;
	logic       sda_d_ff;
	logic       busy_ff;
	logic       ctrl_wr;
	logic       data_wr;
	logic       go;
	logic       tick;
	logic       waiting;
	logic       byte_end;

	assign ctrl_wr  = write_i && (addr_i == CTRL_ADDR);
	assign data_wr  = write_i && (addr_i == DATA_ADDR);
	assign go       = ctrl_wr && wdata_i[FLAG_BIT] && wdata_i[EN_BIT];
	assign tick     = (cnt_ff == RESET_BYTE);
	assign byte_end = (phase_ff == P_BHIGH) && tick && (bitc_ff == LAST_BIT);
	assign waiting  = (phase_ff inside {P_IDLE, P_WAIT, P_HOLD, P_LOST}) ||
		((phase_ff inside {P_BHIGH, P_RSH}) && !scl_s_ff);

	function automatic logic [7:0] ack_status(input logic is_addr, input logic is_read, input logic nack);
		if (!is_addr)
			return nack ? ST_D_NACK : ST_D_ACK;
		else if (is_read)
			return nack ? ST_AR_NACK : ST_AR_ACK;
		else
			return nack ? ST_AW_NACK : ST_AW_ACK;
	endfunction

	// ----------------------------------------------------------------
	// Line synchronisers and bus-busy tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_m_ff <= scl_i;
			scl_s_ff <= scl_m_ff;
			sda_m_ff <= sda_i;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			busy_ff <= 1'b0;
		else if (scl_s_ff && sda_d_ff && !sda_s_ff)
			busy_ff <= 1'b1;
		else if (scl_s_ff && !sda_d_ff && sda_s_ff)
			busy_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Half-period timer, held while waiting or stretched
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i || tick || waiting)
			cnt_ff <= HALF_CYCLES - CNT_ONE;
		else
			cnt_ff <= cnt_ff - CNT_ONE;
	end

	// ----------------------------------------------------------------
	// Bus sequencer, completion flag and status code
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase_ff   <= P_IDLE;
			tx_ff      <= RESET_BYTE;
			bitc_ff    <= BIT_ZERO;
			code_ff    <= ST_IDLE;
			flag_ff    <= 1'b0;
			is_addr_ff <= 1'b0;
			dir_ff     <= 1'b0;
			rs_ff      <= 1'b0;
			pend_ff    <= 1'b0;
			rx_ff      <= 1'b0;
			sto_clr_ff <= 1'b0;
		end else begin
			sto_clr_ff <= 1'b0;
			if (go)
				flag_ff <= 1'b0;
			// Enabling write may carry the first start request
			if (!en_ff && !go) begin
				phase_ff <= P_IDLE;
				code_ff  <= ST_IDLE;
				rx_ff    <= 1'b0;
			end else begin
				unique case (phase_ff)
				P_IDLE: begin
					if (go && wdata_i[STA_BIT]) begin
						phase_ff <= P_WAIT;
						rs_ff    <= 1'b0;
					end
				end
				P_WAIT: begin
					if (!busy_ff)
						phase_ff <= P_START;
				end
				P_START: begin
					if (tick)
						phase_ff <= P_SCLLOW;
				end
				P_SCLLOW: begin
					if (tick) begin
						phase_ff <= P_HOLD;
						flag_ff  <= 1'b1;
						code_ff  <= rs_ff ? ST_RSTART : ST_START;
						rx_ff    <= 1'b0;
					end
				end
				P_HOLD: begin
					if (go) begin
						if (code_ff == ST_START || code_ff == ST_RSTART) begin
							tx_ff      <= data_ff;
							dir_ff     <= data_ff[0];
							is_addr_ff <= 1'b1;
							bitc_ff    <= BIT_ZERO;
							phase_ff   <= P_BLOW;
						end else if (wdata_i[STO_BIT]) begin
							phase_ff <= P_STOP1;
							pend_ff  <= wdata_i[STA_BIT];
						end else if (wdata_i[STA_BIT]) begin
							phase_ff <= P_RS;
						end else if (!rx_ff) begin
							tx_ff      <= data_ff;
							is_addr_ff <= 1'b0;
							bitc_ff    <= BIT_ZERO;
							phase_ff   <= P_BLOW;
						end
					end
				end
				P_BLOW: begin
					if (tick)
						phase_ff <= P_BHIGH;
				end
				P_BHIGH: begin
					if (tick) begin
						if (bitc_ff == LAST_BIT) begin
							phase_ff <= P_HOLD;
							flag_ff  <= 1'b1;
							code_ff  <= ack_status(is_addr_ff, dir_ff, sda_s_ff);
							rx_ff    <= is_addr_ff && dir_ff;
						end else if (tx_ff[7] && !sda_s_ff) begin
							phase_ff <= P_LOST;
							flag_ff  <= 1'b1;
							code_ff  <= ST_ARB;
						end else begin
							tx_ff    <= {tx_ff[6:0], 1'b1};
							bitc_ff  <= bitc_ff + BIT_ONE;
							phase_ff <= P_BLOW;
						end
					end
				end
				P_LOST: begin
					if (go) begin
						if (wdata_i[STA_BIT]) begin
							phase_ff <= P_WAIT;
							rs_ff    <= 1'b0;
						end else begin
							phase_ff <= P_IDLE;
							code_ff  <= ST_IDLE;
						end
					end
				end
				P_RS: begin
					if (tick)
						phase_ff <= P_RSH;
				end
				P_RSH: begin
					if (tick) begin
						phase_ff <= P_START;
						rs_ff    <= 1'b1;
					end
				end
				P_STOP1: begin
					if (tick)
						phase_ff <= P_STOP2;
				end
				P_STOP2: begin
					if (tick)
						phase_ff <= P_STOP3;
				end
				P_STOP3: begin
					if (tick) begin
						sto_clr_ff <= 1'b1;
						rs_ff      <= 1'b0;
						code_ff    <= ST_IDLE;
						phase_ff   <= pend_ff ? P_WAIT : P_IDLE;
					end
				end
				default: phase_ff <= P_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			acken_ff <= 1'b0;
			sta_ff   <= 1'b0;
			sto_ff   <= 1'b0;
			en_ff    <= 1'b0;
			ie_ff    <= 1'b0;
		end else begin
			if (sto_clr_ff)
				sto_ff <= 1'b0;
			if (ctrl_wr) begin
				acken_ff <= wdata_i[ACKEN_BIT];
				sta_ff   <= wdata_i[STA_BIT];
				sto_ff   <= wdata_i[STO_BIT];
				en_ff    <= wdata_i[EN_BIT];
				ie_ff    <= wdata_i[IE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Data, collision and prescaler registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			data_ff <= RESET_BYTE;
			wcol_ff <= 1'b0;
		end else if (data_wr) begin
			if (flag_ff) begin
				data_ff <= wdata_i;
				wcol_ff <= 1'b0;
			end else begin
				wcol_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			presc_ff <= 2'h0;
		else if (write_i && addr_i == STAT_ADDR)
			presc_ff <= wdata_i[1:0];
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i || !read_i)
			rdata_ff <= RESET_BYTE;
		else
			unique case (addr_i)
			CTRL_ADDR: rdata_ff <= {flag_ff, acken_ff, sta_ff, sto_ff, wcol_ff, en_ff, 1'b0, ie_ff};
			STAT_ADDR: rdata_ff <= {code_ff[7:3], 1'b0, presc_ff};
			DATA_ADDR: rdata_ff <= data_ff;
			default:   rdata_ff <= RESET_BYTE;
			endcase
	end

	// ----------------------------------------------------------------
	// Line drivers and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			scl_oe_ff <= en_ff && (phase_ff inside {P_SCLLOW, P_BLOW, P_HOLD, P_RS, P_STOP1});
			sda_oe_ff <= en_ff && ((phase_ff inside {P_START, P_SCLLOW, P_STOP1, P_STOP2}) ||
				((phase_ff inside {P_BLOW, P_BHIGH}) && !tx_ff[7]));
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= flag_ff && ie_ff;
	end

	assign rdata_o   = rdata_ff;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe_o  = scl_oe_ff;
	assign sda_oe_o  = sda_oe_ff;
	assign irq_o     = irq_ff;
	assign rx_mode_o = rx_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_start_status: assert property (
		phase_ff == P_SCLLOW && tick && en_ff && !rs_ff |=> flag_ff && code_ff == ST_START)
		else $error("START not reported as 08");
	a_rstart_status: assert property (
		phase_ff == P_SCLLOW && tick && en_ff && rs_ff |=> flag_ff && code_ff == ST_RSTART)
		else $error("repeated START not reported as 10");
	a_hold_suspend: assert property (
		phase_ff == P_HOLD && en_ff && flag_ff && !go |=> phase_ff == P_HOLD && scl_oe_o)
		else $error("transfer moved while flag set");
	a_wcol_set: assert property (
		data_wr && !flag_ff |=> wcol_ff && $stable(data_ff))
		else $error("data write with flag low not refused");
	a_addr_status: assert property (
		byte_end && en_ff && is_addr_ff && !dir_ff |=>
		code_ff == ($past(sda_s_ff) ? ST_AW_NACK : ST_AW_ACK))
		else $error("address status wrong");
	a_data_status: assert property (
		byte_end && en_ff && !is_addr_ff |=> code_ff == ($past(sda_s_ff) ? ST_D_NACK : ST_D_ACK) && flag_ff)
		else $error("data status wrong");
	a_read_mode: assert property (
		byte_end && en_ff && is_addr_ff && dir_ff |=> rx_mode_o ##1 rx_mode_o)
		else $error("receive mode not entered");
	a_stop_clear: assert property (
		phase_ff == P_STOP3 && tick && en_ff ##1 !ctrl_wr |=> !sto_ff)
		else $error("stop request not cleared");
	a_stop_start: assert property (
		phase_ff == P_STOP3 && tick && en_ff && pend_ff |=> phase_ff == P_WAIT)
		else $error("START after STOP missing");
	a_lost_release: assert property (
		phase_ff == P_LOST && en_ff |=> !sda_oe_o && !scl_oe_o)
		else $error("bus not released after lost arbitration");
	a_irq_follow: assert property (
		flag_ff && ie_ff |=> irq_o)
		else $error("interrupt missing");

	c_data_ack: cover property (code_ff == ST_D_ACK && flag_ff);
	c_arb_lost: cover property (code_ff == ST_ARB && flag_ff);
	c_stop_start: cover property (phase_ff == P_STOP3 ##1 phase_ff == P_WAIT);

endmodule

// ==== bench/slave_model.sv ====
/* Behavioural two-wire slave receiver with an optional rival that holds data low.
 * Assumes open-drain lines resolved by the bench with pull-ups. */
`timescale 1ns/10ps
module slave_model (
	input  wire logic scl_i,   // Clock line level
	input  wire logic sda_i,   // Data line level
	input  wire logic ack_i,   // Acknowledge received bytes
	input  wire logic steal_i, // Rival pulls data low
	output logic      sda_oe_o // Pulls data line low
);
	logic [7:0] sr;
	int         cnt;
	logic       live;
	logic [7:0] got[$];

	initial begin
		sda_oe_o = 1'b0;
		live = 1'b0;
		cnt = 0;
	end
	// Start and stop conditions frame the byte counter
	always @(negedge sda_i) if (scl_i) begin
		live = 1'b1;
		cnt = 0;
	end
	always @(posedge sda_i) if (scl_i) live = 1'b0;
	// Bits MSB first, ninth clock is acknowledge
	always @(posedge scl_i) if (live) begin
		if (cnt < 8) sr = {sr[6:0], sda_i};
		if (cnt == 8) got.push_back(sr);
		cnt = (cnt + 1) % 9;
	end
	always @(negedge scl_i) sda_oe_o = live && ((cnt == 8 && ack_i) || (steal_i && cnt < 8));
	// Rival releases the data line when steal ends
	always @(negedge steal_i) sda_oe_o = 1'b0;
endmodule

// ==== bench/testbench.sv ====
/* Self-checking bench for the two-wire master transmitter.
 * Assumes the slave model on open-drain lines with pull-ups. */
`timescale 1ns/10ps
module testbench
	import two_wire_pkg::*;
;
	logic       clk_i, reset_i, write_i, read_i, ack, steal, a;
	logic [1:0] addr_i;
	logic [7:0] wdata_i, rdata_o, v, b;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, rx_mode_o, s_oe, scl, sda;
	int         error_cnt, checks_done, cyc, dummy;
	logic [7:0] sent[$];

	assign scl = scl_oe_o ? scl_o : 1'b1;
	assign sda = (sda_oe_o ? sda_o : 1'b1) & ~s_oe;

	two_wire_master u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o),
		.rx_mode_o(rx_mode_o));
	slave_model u_slave (.scl_i(scl), .sda_i(sda), .ack_i(ack), .steal_i(steal), .sda_oe_o(s_oe));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ------------------------------------------------
	// Bus tasks
	// ------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= ad;
		wdata_i <= d;
		write_i <= 1'b1;
		@(posedge clk_i);
		write_i <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] ad);
		@(posedge clk_i);
		addr_i <= ad;
		read_i <= 1'b1;
		@(posedge clk_i);
		read_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic wait_irq(input logic [7:0] exp);
		int n;
		n = 0;
		repeat (3) @(posedge clk_i);
		while (irq_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		check({7'h0, irq_o}, 8'h01);
		rd(STAT_ADDR);
		check(v & 8'hF8, exp);
	endtask
	task automatic go(input logic [7:0] c, input logic [7:0] exp);
		wr(CTRL_ADDR, c);
		wait_irq(exp);
	endtask
	task automatic send(input logic [7:0] d, input logic ak, input logic [7:0] exp);
		ack <= ak;
		wr(DATA_ADDR, d);
		sent.push_back(d);
		go(8'h85, exp);
	endtask
	task automatic stop_chk;
		wr(CTRL_ADDR, 8'h95);
		repeat (60) @(posedge clk_i);
		rd(CTRL_ADDR);
		check(v & 8'h90, 8'h00);
		rd(STAT_ADDR);
		check(v, ST_IDLE);
		check({6'h0, scl_oe_o, sda_oe_o}, 8'h00);
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	initial begin
		reset_i = 1'b1;
		write_i = 1'b0;
		read_i = 1'b0;
		addr_i = 2'h0;
		wdata_i = 8'h00;
		ack = 1'b1;
		steal = 1'b0;
		cyc = 0;
		error_cnt = 0;
		checks_done = 0;
		dummy = $urandom(32'hDF17);
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(CTRL_ADDR);
		check(v, 8'h00);
		rd(2'h3);
		check(v, 8'h00);
		wr(STAT_ADDR, 8'h03);
		rd(STAT_ADDR);
		check(v, 8'hFB);
		wr(STAT_ADDR, 8'h00);
		wr(DATA_ADDR, 8'h5A);
		rd(CTRL_ADDR);
		check(v & 8'h08, 8'h08);
		go(8'hA5, ST_START);
		send(8'hA0, 1'b1, ST_AW_ACK);
		rd(CTRL_ADDR);
		check(v & 8'h88, 8'h80);
		repeat (4) begin
			b = 8'($urandom);
			a = 1'($urandom);
			send(b, a, a ? ST_D_ACK : ST_D_NACK);
		end
		repeat (60) @(posedge clk_i);
		check({7'h0, scl_oe_o}, 8'h01);
		check({6'h0, scl_o, sda_o}, 8'h00);
		check(8'(u_slave.got.size()), 8'(sent.size()));
		wr(CTRL_ADDR, 8'h04);
		repeat (3) @(posedge clk_i);
		check({7'h0, irq_o}, 8'h00);
		wr(CTRL_ADDR, 8'h05);
		repeat (3) @(posedge clk_i);
		check({7'h0, irq_o}, 8'h01);
		go(8'hA5, ST_RSTART);
		send(8'hA1, 1'b1, ST_AR_ACK);
		check({7'h0, rx_mode_o}, 8'h01);
		stop_chk();
		go(8'hA5, ST_START);
		send(8'hA2, 1'b0, ST_AW_NACK);
		go(8'hB5, ST_START);
		rd(CTRL_ADDR);
		check(v & 8'h10, 8'h00);
		steal <= 1'b1;
		wr(DATA_ADDR, 8'h50);
		go(8'h85, ST_ARB);
		steal <= 1'b0;
		wr(CTRL_ADDR, 8'h85);
		repeat (40) @(posedge clk_i);
		check({5'h0, scl_oe_o, sda_oe_o, irq_o}, 8'h00);
		go(8'hA5, ST_START);
		steal <= 1'b1;
		wr(DATA_ADDR, 8'h50);
		go(8'h85, ST_ARB);
		wr(CTRL_ADDR, 8'hA5);
		repeat (100) @(posedge clk_i);
		check({7'h0, irq_o}, 8'h00);
		steal <= 1'b0;
		wait_irq(ST_START);
		send(8'hC2, 1'b1, ST_AW_ACK);
		stop_chk();
		check(8'(u_slave.got.size()), 8'(sent.size()));
		foreach (sent[i]) check(u_slave.got[i], sent[i]);
		final_report();
	end
endmodule
